// ---- verilog/windowed_watchdog_regs.sv ----
// Operation
// - window code 1..11 enables windowed mode, closed length 8 ms doubling per step
// - window code zero disables windowed mode; codes above eleven are reserved
// - period code 1..11 enables watchdog with normal time-out; zero turns it off
// - in windowed mode the period code sets the open window length
// - while locked, control register writes are ignored
// - lock bit 7 only writes to one; clearing needs debug mode
// - non-zero period at end of boot sets the lock automatically
// - control write raises sync-pending flag at status bit 0 during transfer
// - hardware clears sync-pending after transfer; software cannot write it
// - lock writes only take effect inside the unlock window
// - sync-pending flag is not guarded by the unlock window
// - status at 0x01 resets to zero; control at 0x00 needs the unlock window
// - control register reset value comes from the boot fuse
// - restart in closed window resets system; missing open window restart resets too
// - restart syncs over oscillator ticks; further restarts meanwhile are ignored
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_regs.svh"
module windowed_watchdog_regs (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic change_protection,
  input wire logic watchdog_restart,
  input wire logic debug_mode,
  input wire logic cpu_halted,
  input wire logic boot_done,
  input wire wdt_pkg::wdt_ctrl_t boot_config_fuse,
  input wire logic wdt_osc,
  output logic system_reset
);
  import wdt_pkg::*;

  wdt_core_if core_bus ();

  wdt_ctrl_t ctrl_q;
  wdt_ctrl_t active_q;
  logic fuse_done_q;
  logic lock_q;
  logic sync_pending_flag_q;
  logic [1:0] cfg_cnt_q;
  logic cfg_load_q;
  logic restart_pend_q;
  logic [1:0] restart_cnt_q;
  logic restart_q;
  logic osc_meta_q;
  logic osc_sync_q;
  logic osc_prev_q;
  logic [7:0] rdata_q;
  logic system_reset_q;
  logic ctrl_wr;
  logic stat_wr;
  logic osc_tick;
  logic cfg_done;
  logic restart_done;

  // oscillator pin is asynchronous: two flops before any edge detect
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_meta_q <= 1'b0;
      osc_sync_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      osc_meta_q <= wdt_osc;
      osc_sync_q <= osc_meta_q;
      osc_prev_q <= osc_sync_q;
    end
  end

  assign osc_tick = osc_sync_q & ~osc_prev_q;

  // protected, unlocked, and only after the fuse value has been taken
  assign ctrl_wr = reg_wr && (reg_addr == `WDT_CTRL_OFS) && change_protection
    && !lock_q && fuse_done_q;
  assign stat_wr = reg_wr && (reg_addr == `WDT_STAT_OFS) && change_protection;
  assign cfg_done = sync_pending_flag_q && osc_tick && (cfg_cnt_q == `WDT_SYNC_TICKS - 2'h1);
  assign restart_done = restart_pend_q && osc_tick
    && (restart_cnt_q == `WDT_SYNC_TICKS - 2'h1);

  // control register: fuse value taken once after reset release
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `WDT_CTRL_RST;
      fuse_done_q <= 1'b0;
    end else if (!fuse_done_q) begin
      ctrl_q <= boot_config_fuse;
      fuse_done_q <= 1'b1;
    end else if (ctrl_wr) begin
      ctrl_q <= reg_wdata;
    end
  end

  // value seen by the timing core, loaded at fuse time or when a transfer ends
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      active_q <= `WDT_CTRL_RST;
      cfg_load_q <= 1'b0;
    end else begin
      cfg_load_q <= 1'b0;
      if (!fuse_done_q) begin
        active_q <= boot_config_fuse;
        cfg_load_q <= 1'b1;
      end else if (cfg_done && !ctrl_wr) begin
        active_q <= ctrl_q;
        cfg_load_q <= 1'b1;
      end
    end
  end

  // sync-pending flag; a new write wins over completion and restarts the transfer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_pending_flag_q <= 1'b0;
      cfg_cnt_q <= 2'h0;
    end else if (ctrl_wr) begin
      sync_pending_flag_q <= 1'b1;
      cfg_cnt_q <= 2'h0;
    end else if (cfg_done) begin
      sync_pending_flag_q <= 1'b0;
      cfg_cnt_q <= 2'h0;
    end else if (sync_pending_flag_q && osc_tick) begin
      cfg_cnt_q <= cfg_cnt_q + 2'h1;
    end
  end

  // lock: set by software write of one or at end of boot, cleared only in debug
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_q <= 1'b0;
    end else if (boot_done && ctrl_q.period != `WDT_CODE_OFF && fuse_done_q) begin
      lock_q <= 1'b1;
    end else if (stat_wr && reg_wdata[`WDT_LOCK_BIT]) begin
      lock_q <= 1'b1;
    end else if (stat_wr && debug_mode) begin
      lock_q <= 1'b0;
    end
  end

  // restart synchronisation; extra restarts while pending are dropped
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      restart_pend_q <= 1'b0;
      restart_cnt_q <= 2'h0;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      if (restart_done) begin
        restart_pend_q <= 1'b0;
        restart_cnt_q <= 2'h0;
        restart_q <= 1'b1;
      end else if (restart_pend_q) begin
        if (osc_tick) begin
          restart_cnt_q <= restart_cnt_q + 2'h1;
        end
      end else if (watchdog_restart) begin
        restart_pend_q <= 1'b1;
        restart_cnt_q <= 2'h0;
      end
    end
  end

  assign core_bus.osc_tick = osc_tick;
  assign core_bus.cfg_load = cfg_load_q;
  assign core_bus.cfg = active_q;
  assign core_bus.restart = restart_q;
  assign core_bus.halt = cpu_halted;

  wdt_timeout_core #(
    .CNT_W(14)
  ) u_core (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .core(core_bus.core)
  );

  // reset request held until the chip reset takes this block down
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      system_reset_q <= 1'b0;
    end else if (core_bus.fire) begin
      system_reset_q <= 1'b1;
    end
  end

  // read data valid only in the cycle after the read strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (reg_rd && reg_addr == `WDT_CTRL_OFS) begin
      rdata_q <= ctrl_q;
    end else if (reg_rd && reg_addr == `WDT_STAT_OFS) begin
      rdata_q <= `WDT_STAT_RST;
      rdata_q[`WDT_LOCK_BIT] <= lock_q;
      rdata_q[`WDT_SYNC_BIT] <= sync_pending_flag_q;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign system_reset = system_reset_q;
endmodule : windowed_watchdog_regs
`default_nettype wire

// ---- verilog/wdt_regs.svh ----
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH
`define WDT_CTRL_OFS 8'h00
`define WDT_STAT_OFS 8'h01
`define WDT_LOCK_BIT 7
`define WDT_SYNC_BIT 0
`define WDT_WIN_MSB 7
`define WDT_WIN_LSB 4
`define WDT_PER_MSB 3
`define WDT_PER_LSB 0
`define WDT_STAT_RST 8'h00
`define WDT_CTRL_RST 8'h00
`define WDT_CODE_OFF 4'h0
`define WDT_CODE_MAX 4'hB
`define WDT_BASE_TICKS 14'h0008
`define WDT_SYNC_TICKS 2'h2
`endif

// ---- verilog/wdt_pkg.sv ----
`default_nettype none
package wdt_pkg;
  typedef enum logic [3:0] {
    WD_OFF = 4'b0001,
    WD_FREE = 4'b0010,
    WD_CLOSED = 4'b0100,
    WD_OPEN = 4'b1000
  } wd_state_t;
  typedef struct packed {
    logic [3:0] window;
    logic [3:0] period;
  } wdt_ctrl_t;
endpackage : wdt_pkg
`default_nettype wire

// ---- verilog/wdt_core_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface wdt_core_if;
  import wdt_pkg::*;
  logic osc_tick;
  logic cfg_load;
  wdt_ctrl_t cfg;
  logic restart;
  logic halt;
  logic fire;
  wd_state_t state;
  modport regs (output osc_tick, output cfg_load, output cfg, output restart, output halt,
    input fire, input state);
  modport core (input osc_tick, input cfg_load, input cfg, input restart, input halt,
    output fire, output state);
endinterface : wdt_core_if
`default_nettype wire

// ---- verilog/wdt_timeout_core.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "wdt_regs.svh"
module wdt_timeout_core #(
  parameter int CNT_W = 14
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  wdt_core_if.core core
);
  import wdt_pkg::*;

  wd_state_t state_q;
  logic [CNT_W-1:0] count_q;
  logic fire_q;
  logic [CNT_W-1:0] count_inc;

  // code n gives 8 << (n-1) oscillator ticks; reserved codes clamp to the longest
  function automatic logic [CNT_W-1:0] code_len(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `WDT_CODE_MAX) ? `WDT_CODE_MAX : code;
    code_len = CNT_W'(`WDT_BASE_TICKS) << (c - 4'h1);
  endfunction : code_len

  assign count_inc = count_q + CNT_W'(1);
  assign core.fire = fire_q;
  assign core.state = state_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= WD_OFF;
      count_q <= '0;
      fire_q <= 1'b0;
    end else begin
      fire_q <= 1'b0;
      if (core.cfg_load || core.halt) begin
        // new setting or debug halt: counter cleared, first closed window skipped
        count_q <= '0;
        state_q <= (core.cfg.period != `WDT_CODE_OFF) ? WD_FREE : WD_OFF;
      end else if (core.restart && state_q != WD_OFF) begin
        count_q <= '0;
        if (state_q == WD_CLOSED) begin
          fire_q <= 1'b1;
        end else if (core.cfg.window != `WDT_CODE_OFF) begin
          state_q <= WD_CLOSED;
        end else begin
          state_q <= WD_FREE;
        end
      end else if (core.osc_tick) begin
        unique case (state_q)
          WD_OFF: begin
            count_q <= '0;
          end
          WD_FREE, WD_OPEN: begin
            if (count_inc >= code_len(core.cfg.period)) begin
              fire_q <= 1'b1;
              count_q <= '0;
            end else begin
              count_q <= count_inc;
            end
          end
          WD_CLOSED: begin
            if (count_inc >= code_len(core.cfg.window)) begin
              state_q <= WD_OPEN;
              count_q <= '0;
            end else begin
              count_q <= count_inc;
            end
          end
        endcase
      end
    end
  end
endmodule : wdt_timeout_core
`default_nettype wire

// ---- tb/wdt_regs_chk_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module wdt_regs_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic change_protection,
  input wire logic watchdog_restart,
  input wire logic debug_mode,
  input wire logic cpu_halted,
  input wire logic boot_done,
  input wire wdt_pkg::wdt_ctrl_t boot_config_fuse,
  input wire logic wdt_osc,
  input wire logic system_reset
);
  import wdt_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer");
  a_stat_spare: assert property (reg_rd && reg_addr == 8'h01 |=> reg_rdata[6:1] == 6'h00)
    else $error("status spare bits set");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h01 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reset_held: assert property (system_reset |=> system_reset)
    else $error("system reset dropped");
  a_halt_quiet: assert property (cpu_halted [*3] |-> !$rose(system_reset))
    else $error("reset while halted");
  a_ctrl_guard: assert property (
    reg_rd && reg_addr == 8'h00 ##2 reg_wr && reg_addr == 8'h00 && !change_protection
    ##2 reg_rd && reg_addr == 8'h00 |=> reg_rdata == $past(reg_rdata, 4)) else $error("unguarded write took");
  a_sync_raise: assert property (
    reg_rd && reg_addr == 8'h01 && !boot_done ##1 !reg_rdata[7] ##1 reg_wr && reg_addr == 8'h00 && change_protection
    ##2 reg_rd && reg_addr == 8'h01 |=> reg_rdata[0]) else $error("sync flag not raised");
  a_lock_sticky: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h01 && reg_rdata[7] && !debug_mode ##1 !debug_mode [*3]
    ##0 reg_rd && reg_addr == 8'h01 |=> reg_rdata[7]) else $error("lock cleared outside debug");
  c_fired: cover property (system_reset);
  c_lock_wr: cover property (reg_wr && reg_addr == 8'h01 && change_protection);
  c_restart: cover property (watchdog_restart);
endmodule : wdt_regs_chk
bind windowed_watchdog_regs wdt_regs_chk u_wdt_regs_chk (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .change_protection, .watchdog_restart, .debug_mode, .cpu_halted, .boot_done,
  .boot_config_fuse, .wdt_osc, .system_reset);
`default_nettype wire

// ---- tb/windowed_watchdog_regs_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module windowed_watchdog_regs_tb_top;
  import wdt_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, change_protection = 1'b0;
  logic watchdog_restart = 1'b0, debug_mode = 1'b0, cpu_halted = 1'b0, boot_done = 1'b0, wdt_osc = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  wdt_ctrl_t boot_config_fuse = 8'h00;
  logic [7:0] reg_rdata;
  logic system_reset;
  int err_total = 0, checks_done = 0;
  always #5 sys_clk = ~sys_clk;
  windowed_watchdog_regs u_windowed_watchdog_regs (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .change_protection, .watchdog_restart, .debug_mode, .cpu_halted, .boot_done,
    .boot_config_fuse, .wdt_osc, .system_reset);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic cp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    change_protection <= cp;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    change_protection <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd
  // slow oscillator ticks, each well past the two-flop synchronizer
  task automatic tk(input int n);
    repeat (n) begin
      repeat (5) @(posedge sys_clk);
      wdt_osc <= 1'b1;
      repeat (5) @(posedge sys_clk);
      wdt_osc <= 1'b0;
    end
    #1;
  endtask : tk
  task automatic kick;
    @(posedge sys_clk);
    watchdog_restart <= 1'b1;
    @(posedge sys_clk);
    watchdog_restart <= 1'b0;
  endtask : kick
  task automatic rst;
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask : rst
  task automatic t_regs;
    cpu_halted <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cpu_halted <= 1'b0;
    rd(8'h00, 8'h00);
    wr(8'h00, 8'h12, 1'b0);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    wr(8'h00, 8'h12, 1'b1);
    rd(8'h01, 8'h01);
    tk(4);
    rd(8'h01, 8'h00);
    rd(8'h00, 8'h12);
    wr(8'h01, 8'h01, 1'b1);
    rd(8'h01, 8'h00);
    wr(8'h05, 8'hFF, 1'b1);
    rd(8'h05, 8'h00);
    for (int i = 0; i < 12; i++) begin
      wr(8'h00, {i[3:0], 4'h0}, 1'b1);
      tk(3);
      rd(8'h00, {i[3:0], 4'h0});
    end
    $display("t_regs done");
  endtask : t_regs
  task automatic t_lock;
    wr(8'h01, 8'h80, 1'b0);
    rd(8'h01, 8'h00);
    wr(8'h00, 8'h02, 1'b1);
    tk(3);
    @(posedge sys_clk);
    boot_done <= 1'b1;
    @(posedge sys_clk);
    boot_done <= 1'b0;
    rd(8'h01, 8'h80);
    wr(8'h00, 8'h34, 1'b1);
    rd(8'h00, 8'h02);
    rd(8'h01, 8'h80);
    wr(8'h01, 8'h00, 1'b1);
    rd(8'h01, 8'h80);
    @(posedge sys_clk);
    debug_mode <= 1'b1;
    wr(8'h01, 8'h00, 1'b1);
    rd(8'h01, 8'h00);
    @(posedge sys_clk);
    debug_mode <= 1'b0;
    $display("t_lock done");
  endtask : t_lock
  task automatic t_normal;
    wr(8'h00, 8'h01, 1'b1);
    tk(3);
    kick;
    tk(9);
    chk({7'h00, system_reset}, 8'h00);
    tk(2);
    chk({7'h00, system_reset}, 8'h01);
    $display("t_normal done");
  endtask : t_normal
  task automatic t_window;
    wr(8'h00, 8'h11, 1'b1);
    tk(3);
    kick;
    kick;
    tk(4);
    chk({7'h00, system_reset}, 8'h00);
    kick;
    tk(3);
    chk({7'h00, system_reset}, 8'h01);
    $display("t_window done");
  endtask : t_window
  task automatic t_open;
    wr(8'h00, 8'h12, 1'b1);
    tk(3);
    kick;
    tk(12);
    kick;
    tk(23);
    chk({7'h00, system_reset}, 8'h00);
    tk(4);
    chk({7'h00, system_reset}, 8'h01);
    $display("t_open done");
  endtask : t_open
  // non-zero fuse: watchdog runs from reset in windowed mode, closed window skipped
  task automatic t_fuse;
    @(posedge sys_clk);
    boot_config_fuse <= 8'h13;
    rst;
    rd(8'h00, 8'h13);
    @(posedge sys_clk);
    boot_done <= 1'b1;
    @(posedge sys_clk);
    boot_done <= 1'b0;
    rd(8'h01, 8'h80);
    tk(31);
    chk({7'h00, system_reset}, 8'h00);
    tk(1);
    chk({7'h00, system_reset}, 8'h01);
    $display("t_fuse done");
  endtask : t_fuse
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  initial begin
    rst;
    t_regs;
    t_lock;
    t_normal;
    rst;
    t_window;
    rst;
    t_open;
    t_fuse;
    summarize;
  end
  initial begin
    #500us;
    err_total++;
    summarize;
  end
endmodule : windowed_watchdog_regs_tb_top
`default_nettype wire
